// file: design/sbc_boost_ctrl.v
// Smart boost control: registers, mode decode and raise decision
`timescale 1ns/1ps
`include "sbc_defines.vh"

module sbc_boost_ctrl #(
  parameter LW = 6, // Signal level width (full scale = 64)
  parameter CW = 26 // Deglitch counter width
) (
  input wire sys_clk, // 20 MHz system clock
  input wire nrst, // Async reset, active low
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  input wire [7:0] reg_addr, // Register address
  input wire [15:0] reg_wdata, // Register write data
  input wire [LW-1:0] signal_level, // Audio level in 1/64 full scale
  input wire [9:0] battery_meas, // Battery measurement result
  input wire [9:0] temp_meas, // Die temperature result
  input wire meas_valid, // Measurement results update strobe
  input wire [3:0] demand_code, // Voltage code the signal asks for
  output reg [15:0] reg_rdata, // Register read data
  output reg boost_raise, // Raise rail above battery
  output reg [3:0] out_voltage_code, // Output voltage code in force
  output reg [2:0] mode_out // Mode select code in force, registered
);
  // ****************************************
  // Configuration and status storage
  // ****************************************
  reg [5:0] release_level_reg;
  reg [5:0] attack_level_reg;
  reg [2:0] boost_mode_sel_reg;
  reg [2:0] small_signal_deglitch_reg;
  reg [3:0] max_out_voltage_code_reg;
  reg [9:0] battery_level_code_reg;
  reg [9:0] die_temp_code_reg;
  reg raise_reg;
  reg raise_next;
  reg [15:0] rdata_next;
  reg [CW-1:0] deg_limit;
  wire smart;
  wire low_ok;
  wire deg_done;
  reg [3:0] code_next;

  // ****************************************
  // Decode functions
  // ****************************************
  // Deglitch limit in cycles for a given code
  function [CW-1:0] deg_cycles;
    input [2:0] code;
    reg [63:0] t;
    begin
      case (code)
        3'h0: t = `SBC_DEG_US100_0;
        3'h1: t = `SBC_DEG_US100_1;
        3'h2: t = `SBC_DEG_US100_2;
        3'h3: t = `SBC_DEG_US100_3;
        3'h4: t = `SBC_DEG_US100_4;
        3'h5: t = `SBC_DEG_US100_5;
        3'h6: t = `SBC_DEG_US100_6;
        default: t = `SBC_DEG_US100_7;
      endcase
      t = (t * `SBC_CLK_MHZ) / `SBC_DEG_SCALE;
      deg_cycles = t[CW-1:0];
    end
  endfunction

  // Smart mode decode
  function is_smart;
    input [2:0] m;
    begin
      is_smart = (m == `SBC_MODE_SMART1) || (m == `SBC_MODE_SMART2);
    end
  endfunction

  assign smart = is_smart(boost_mode_sel_reg);

  // ****************************************
  // Register writes and measurement capture
  // ****************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      release_level_reg <= `SBC_RST_RELEASE;
      attack_level_reg <= `SBC_RST_ATTACK;
      boost_mode_sel_reg <= `SBC_RST_MODE;
      small_signal_deglitch_reg <= `SBC_RST_DEGLITCH;
      max_out_voltage_code_reg <= `SBC_RST_MAXV;
      battery_level_code_reg <= `SBC_RST_VBAT;
      die_temp_code_reg <= `SBC_RST_TEMP;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `SBC_ADDR_THRESHOLD: begin
            release_level_reg <= reg_wdata[`SBC_REL_HI:`SBC_REL_LO];
            attack_level_reg <= reg_wdata[`SBC_ATT_HI:`SBC_ATT_LO];
          end
          `SBC_ADDR_MODE: begin
            boost_mode_sel_reg <= reg_wdata[`SBC_MODE_HI:`SBC_MODE_LO];
            small_signal_deglitch_reg <= reg_wdata[`SBC_DEG_HI:`SBC_DEG_LO];
          end
          `SBC_ADDR_MAXV: begin
            max_out_voltage_code_reg <= reg_wdata[`SBC_MAXV_HI:`SBC_MAXV_LO];
          end
          default: begin
            // Read-only and unmapped addresses ignore writes
          end
        endcase
      end
      if (meas_valid) begin
        battery_level_code_reg <= battery_meas;
        die_temp_code_reg <= temp_meas;
      end
    end
  end

  // ****************************************
  // Boost decision
  // ****************************************
  always @* begin
    deg_limit = deg_cycles(small_signal_deglitch_reg);
  end

  // Small-signal condition that feeds the deglitch timer
  assign low_ok = smart && (signal_level < release_level_reg);

  // The small signal must last the chosen time before the rail drops
  sbc_deglitch_timer #(
    .CW(CW)
  ) u_deglitch (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .cond(low_ok),
    .limit(deg_limit),
    .done(deg_done)
  );

  // Next raise state by mode and level
  always @* begin
    raise_next = raise_reg;
    case (boost_mode_sel_reg)
      `SBC_MODE_PASS: raise_next = 1'b0;
      `SBC_MODE_FORCE: raise_next = 1'b1;
      `SBC_MODE_SMART1, `SBC_MODE_SMART2: begin
        // Done lags the level by a cycle, so it is qualified live
        if (signal_level > attack_level_reg)
          raise_next = 1'b1;
        else if (deg_done && low_ok)
          raise_next = 1'b0;
        else
          raise_next = raise_reg;
      end
      default: raise_next = 1'b0;
    endcase
  end

  // Voltage in force: zero when unraised, max code in force mode, else demand limited by max code
  always @* begin
    if (!raise_next) begin
      code_next = 4'h0;
    end else if (boost_mode_sel_reg == `SBC_MODE_FORCE) begin
      code_next = max_out_voltage_code_reg;
    end else if (demand_code > max_out_voltage_code_reg) begin
      code_next = max_out_voltage_code_reg;
    end else begin
      code_next = demand_code;
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Read mux
  always @* begin
    case (reg_addr)
      `SBC_ADDR_THRESHOLD: rdata_next = {2'h0, release_level_reg,
        2'h0, attack_level_reg};
      `SBC_ADDR_MODE: rdata_next = {9'h000, boost_mode_sel_reg,
        1'b0, small_signal_deglitch_reg};
      `SBC_ADDR_MAXV: rdata_next = {12'h000,
        max_out_voltage_code_reg};
      `SBC_ADDR_VBAT: rdata_next = {6'h00, battery_level_code_reg};
      `SBC_ADDR_TEMP: rdata_next = {6'h00, die_temp_code_reg};
      default: rdata_next = 16'h0000;
    endcase
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Raise state, the outputs that follow it, and the registered mode output
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      raise_reg <= 1'b0;
      boost_raise <= 1'b0;
      out_voltage_code <= 4'h0;
      mode_out <= `SBC_RST_MODE;
    end else begin
      raise_reg <= raise_next;
      boost_raise <= raise_next;
      out_voltage_code <= code_next;
      mode_out <= boost_mode_sel_reg;
    end
  end

  // Read data is captured on the read strobe and held until the next one
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule

// file: design/sbc_defines.vh
// Register map, field layout, reset values and timing constants
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// ****************************************
// Register addresses (8-bit register index)
// ****************************************
`define SBC_ADDR_THRESHOLD 8'h60
`define SBC_ADDR_MODE 8'h61
`define SBC_ADDR_MAXV 8'h62
`define SBC_ADDR_VBAT 8'h6d
`define SBC_ADDR_TEMP 8'h6e

// ****************************************
// Reset values
// ****************************************
`define SBC_RST_RELEASE 6'h04
`define SBC_RST_ATTACK 6'h02
`define SBC_RST_MODE 3'h2
`define SBC_RST_DEGLITCH 3'h6
`define SBC_RST_MAXV 4'h8
`define SBC_RST_VBAT 10'h263
`define SBC_RST_TEMP 10'h019

// ****************************************
// Field positions
// ****************************************
`define SBC_REL_HI 13
`define SBC_REL_LO 8
`define SBC_ATT_HI 5
`define SBC_ATT_LO 0
`define SBC_MODE_HI 6
`define SBC_MODE_LO 4
`define SBC_DEG_HI 2
`define SBC_DEG_LO 0
`define SBC_MAXV_HI 3
`define SBC_MAXV_LO 0
`define SBC_MEAS_HI 9
`define SBC_MEAS_LO 0

// ****************************************
// Boost mode codes
// ****************************************
`define SBC_MODE_PASS 3'h0
`define SBC_MODE_FORCE 3'h1
`define SBC_MODE_SMART1 3'h5
`define SBC_MODE_SMART2 3'h6

// ****************************************
// Deglitch times in microseconds (x100 for 10 ns resolution)
// ****************************************
`define SBC_DEG_US100_0 64'd133000
`define SBC_DEG_US100_1 64'd266000
`define SBC_DEG_US100_2 64'd532000
`define SBC_DEG_US100_3 64'd2130000
`define SBC_DEG_US100_4 64'd8520000
`define SBC_DEG_US100_5 64'd34079000
`define SBC_DEG_US100_6 64'd136300000
`define SBC_DEG_US100_7 64'd273000000
`define SBC_CLK_MHZ 64'd20
`define SBC_DEG_SCALE 64'd100

`endif

// file: design/sbc_deglitch_timer.v
// Small-signal deglitch timer: counts while the low condition persists
`timescale 1ns/1ps
module sbc_deglitch_timer #(
  parameter CW = 26
) (
  input wire sys_clk, // System clock
  input wire nrst, // Async reset, active low
  input wire cond, // Condition being qualified
  input wire [CW-1:0] limit, // Cycles the condition must last
  output reg done // Condition held for the full time
);
  reg [CW-1:0] cnt_reg;

  // Restart whenever the condition drops; saturate at the limit
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= {CW{1'b0}};
      done <= 1'b0;
    end else if (!cond) begin
      cnt_reg <= {CW{1'b0}};
      done <= 1'b0;
    end else if (cnt_reg >= limit) begin
      done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      done <= 1'b0;
    end
  end
endmodule

// file: verification/sbc_monitor.sv
// Concurrent checks on the smart boost control ports
`timescale 1ns/1ps
module sbc_monitor #(parameter LW = 6, parameter CW = 26) (
  input wire sys_clk, // Clock
  input wire nrst, // Reset
  input wire reg_wr, // Write
  input wire reg_rd, // Read
  input wire [7:0] reg_addr, // Address
  input wire [15:0] reg_wdata, // Wdata
  input wire [LW-1:0] signal_level, // Level
  input wire [9:0] battery_meas, // Battery
  input wire [9:0] temp_meas, // Temp
  input wire meas_valid, // Capture
  input wire [3:0] demand_code, // Demand
  input wire [15:0] reg_rdata, // Rdata
  input wire boost_raise, // Raised
  input wire [3:0] out_voltage_code, // Code
  input wire [2:0] mode_out // Mode
);
  reg [5:0] att_s;
  reg [5:0] rel_s;
  reg [3:0] mx_s;
  reg mq;
  wire smart = mode_out == 3'h5 || mode_out == 3'h6;
  // Shadow the threshold and max code fields; mq marks a mode write last cycle
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      att_s <= 6'h02;
      rel_s <= 6'h04;
      mx_s <= 4'h8;
      mq <= 1'b0;
    end else begin
      mq <= reg_wr && reg_addr == 8'h61;
      if (reg_wr && reg_addr == 8'h60) begin
        rel_s <= reg_wdata[13:8];
        att_s <= reg_wdata[5:0];
      end
      if (reg_wr && reg_addr == 8'h62) begin
        mx_s <= reg_wdata[3:0];
      end
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_smart;
    smart && !mq;
  endsequence
  sequence s_pass;
    mode_out == 3'h0 && !mq;
  endsequence
  sequence s_force;
    mode_out == 3'h1 && !mq;
  endsequence
  a_pass_low: assert property (s_pass[*2] |-> !boost_raise)
    else $error("pass mode raised");
  a_force_high: assert property (s_force[*2] |-> boost_raise
    && out_voltage_code == $past(mx_s)) else $error("force mode wrong");
  a_attack_raise: assert property (s_smart[*2] ##0
    (signal_level > att_s) |=> boost_raise) else $error("no raise");
  a_raise_cause: assert property (s_smart ##0 $rose(boost_raise)
    |-> $past(signal_level) > $past(att_s)) else $error("bad raise");
  a_fall_cause: assert property (s_smart ##0 $fell(boost_raise)
    |-> $past(signal_level) < $past(rel_s)) else $error("bad lower");
  a_band_hold: assert property (s_smart[*2] ##0
    (signal_level <= att_s && signal_level >= rel_s)
    |=> $stable(boost_raise)) else $error("no hold");
  a_idle_code: assert property (!boost_raise |->
    out_voltage_code == 4'h0) else $error("idle code");
  a_code_limit: assert property (boost_raise |->
    out_voltage_code <= $past(mx_s)) else $error("code above max");
  a_read_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule
bind sbc_boost_ctrl sbc_monitor #(.LW(LW), .CW(CW)) u_mon (
  .sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .signal_level(signal_level), .battery_meas(battery_meas),
  .temp_meas(temp_meas), .meas_valid(meas_valid),
  .demand_code(demand_code), .reg_rdata(reg_rdata),
  .boost_raise(boost_raise), .out_voltage_code(out_voltage_code),
  .mode_out(mode_out));

// file: verification/tb_sbc_boost_ctrl.sv
// Self-checking bench for the smart boost control block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared = n_compared + 1; if ((a) !== (e)) begin \
  n_errors = n_errors + 1; $display("Error t=%0t got %h exp %h", $time, a, e); \
  end end
module tb_sbc_boost_ctrl;
  reg sys_clk = 0;
  reg nrst = 0;
  reg reg_wr = 0;
  reg reg_rd = 0;
  reg [7:0] reg_addr = 0;
  reg [15:0] reg_wdata = 0;
  reg [5:0] signal_level = 0;
  reg [9:0] battery_meas = 0;
  reg [9:0] temp_meas = 0;
  reg meas_valid = 0;
  reg [3:0] demand_code = 4'hf;
  wire [15:0] reg_rdata;
  wire boost_raise;
  wire [3:0] out_voltage_code;
  wire [2:0] mode_out;
  reg [40:0] rows [0:8];
  reg [3:0] ec;
  integer n_errors = 0;
  integer n_compared = 0;
  integer i;
  // Clock of 50 ns period
  always #25 sys_clk = ~sys_clk;
  sbc_boost_ctrl uut (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .signal_level(signal_level), .battery_meas(battery_meas),
    .temp_meas(temp_meas), .meas_valid(meas_valid),
    .demand_code(demand_code), .reg_rdata(reg_rdata),
    .boost_raise(boost_raise), .out_voltage_code(out_voltage_code),
    .mode_out(mode_out));
  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #2;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = d;
      tick(1);
      reg_wr = 0;
      tick(1);
    end
  endtask
  task rd(input [7:0] a);
    begin
      reg_rd = 1;
      reg_addr = a;
      tick(1);
      reg_rd = 0;
      tick(1);
    end
  endtask
  task summarize;
    begin
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Watchdog well past the planned run length
  initial begin
    #3500000;
    n_errors = n_errors + 1;
    summarize;
  end
  // Rows: write flag, address, write data, expected read data
  initial begin
    rows[0] = {1'b0, 8'h61, 16'h0000, 16'h0026};
    rows[1] = {1'b0, 8'h60, 16'h0000, 16'h0402};
    rows[2] = {1'b0, 8'h62, 16'h0000, 16'h0008};
    rows[3] = {1'b1, 8'h60, 16'hffff, 16'h3f3f};
    rows[4] = {1'b1, 8'h61, 16'hffff, 16'h0077};
    rows[5] = {1'b1, 8'h62, 16'hffff, 16'h000f};
    rows[6] = {1'b1, 8'h6d, 16'hffff, 16'h0263};
    rows[7] = {1'b1, 8'h6e, 16'hffff, 16'h0019};
    rows[8] = {1'b1, 8'h63, 16'hffff, 16'h0000};
    tick(3);
    `CHK(mode_out, 3'h2)
    `CHK(boost_raise, 1'b0)
    nrst = 1;
    for (i = 0; i < 9; i = i + 1) begin
      if (rows[i][40]) wr(rows[i][39:32], rows[i][31:16]);
      rd(rows[i][39:32]);
      `CHK(reg_rdata, rows[i][15:0])
    end
    $display("register rows done");
    battery_meas = 10'h3ff;
    temp_meas = 10'h3d8;
    meas_valid = 1;
    tick(1);
    meas_valid = 0;
    rd(8'h6d);
    `CHK(reg_rdata, 16'h03ff)
    rd(8'h6e);
    `CHK(reg_rdata, 16'h03d8)
    $display("measurement test done");
    wr(8'h60, 16'h0414);
    wr(8'h62, 16'h000c);
    signal_level = 6'h3f;
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h61, {9'h0, i[2:0], 4'h0});
      tick(3);
      ec = (i == 1 || i == 5 || i == 6) ? 4'hc : 4'h0;
      `CHK(out_voltage_code, ec)
      `CHK(boost_raise, ec != 4'h0)
      `CHK(mode_out, i[2:0])
    end
    $display("mode table done");
    demand_code = 4'h5;
    signal_level = 6'h14;
    wr(8'h61, 16'h0050);
    tick(3);
    `CHK(boost_raise, 1'b0)
    signal_level = 6'h15;
    tick(2);
    `CHK(out_voltage_code, 4'h5)
    signal_level = 6'h04;
    tick(26650);
    `CHK(boost_raise, 1'b1)
    signal_level = 6'h03;
    tick(26580);
    `CHK(boost_raise, 1'b1)
    tick(70);
    `CHK(boost_raise, 1'b0)
    $display("smart boost test done");
    wr(8'h61, 16'h0010);
    tick(1);
    `CHK(boost_raise, 1'b1)
    nrst = 0;
    tick(2);
    `CHK(boost_raise, 1'b0)
    `CHK(out_voltage_code, 4'h0)
    `CHK(mode_out, 3'h2)
    `CHK(reg_rdata, 16'h0000)
    nrst = 1;
    rd(8'h60);
    `CHK(reg_rdata, 16'h0402)
    rd(8'h6d);
    `CHK(reg_rdata, 16'h0263)
    $display("mid-run reset test done");
    summarize;
  end
endmodule
